// ==== gateway_link_if.sv ====
// Purpose: link between a message originator and the gateway router
// Assumes: one clock, originator holds req_valid until req_ready
// Notes:   route is up to four drops, first drop in bits 7:0
`timescale 1ns/1ps
interface gateway_link_if
   import gateway_router_pkg::*;
   (input wire logic clk_sys);
   logic        req_valid;
   logic        req_ready;
   logic [7:0]  req_opcode;
   logic        req_is_modbus;
   logic [3:0]  req_space_digit;
   logic [2:0]  req_route_len;
   logic [31:0] req_route;
   logic [15:0] req_addr;
   logic [15:0] req_data;
   logic [15:0] req_mask;
   logic [7:0]  req_target;
   logic        rsp_valid;
   logic        rsp_local;
   logic        rsp_error;
   logic [15:0] rsp_data;
   logic [7:0]  rsp_slot;

   modport router (input req_valid, req_opcode, req_is_modbus, req_space_digit,
                   req_route_len, req_route, req_addr, req_data, req_mask, req_target,
                   output req_ready, rsp_valid, rsp_local, rsp_error, rsp_data, rsp_slot);
   modport originator (output req_valid, req_opcode, req_is_modbus, req_space_digit,
                       req_route_len, req_route, req_addr, req_data, req_mask, req_target,
                       input req_ready, rsp_valid, rsp_local, rsp_error, rsp_data, rsp_slot);
endinterface : gateway_link_if

// ==== gateway_link_sva.sv ====
// Purpose: checker on the link between originator and router
// Assumes: plain copies of gateway_link_if signals, one clock domain
// Notes:   request fields are captured while valid waits for ready
`timescale 1ns/1ps
module gateway_link_sva
#(
   parameter int REG_DEPTH = 256
)(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [7:0]  req_opcode,
   input wire logic        req_is_modbus,
   input wire logic [3:0]  req_space_digit,
   input wire logic [2:0]  req_route_len,
   input wire logic [15:0] req_addr,
   input wire logic        rsp_valid,
   input wire logic        rsp_local,
   input wire logic        rsp_error,
   input wire logic [15:0] rsp_data,
   input wire logic [7:0]  rsp_slot
);
   logic [7:0]  op_reg;
   logic        mb_reg;
   logic [3:0]  dig_reg;
   logic [2:0]  len_reg;
   logic [15:0] addr_reg;
   logic        ok_addr;

   // originator may drop the fields once ready lands, so keep them here
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         op_reg   <= 8'h00;
         mb_reg   <= 1'b0;
         dig_reg  <= 4'h0;
         len_reg  <= 3'h0;
         addr_reg <= 16'h0000;
      end
      else if (req_valid && !req_ready)
      begin
         op_reg   <= req_opcode;
         mb_reg   <= req_is_modbus;
         dig_reg  <= req_space_digit;
         len_reg  <= req_route_len;
         addr_reg <= req_addr;
      end
   end

   // one-based address inside local storage
   assign ok_addr = (addr_reg != 16'h0000) && (int'(addr_reg) <= REG_DEPTH);

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   ready_after_take_a: assert property ($rose(req_valid) |=> req_ready)
      else $error("ready missing one cycle after take");
   answer_follows_a: assert property (req_ready |=> rsp_valid && !req_ready)
      else $error("answer not one cycle after ready");
   rsp_single_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer valid longer than one cycle");
   // fields reload at the take and in exec, shadowed by ready and valid
   rsp_hold_a: assert property (!rsp_valid && !req_ready
      |-> $stable({rsp_local, rsp_error, rsp_data, rsp_slot}))
      else $error("answer fields moved between answers");
   no_route_local_a: assert property (rsp_valid && !mb_reg && len_reg == 3'h0 |-> rsp_local)
      else $error("routeless message not local");
   addr_zero_a: assert property (rsp_valid && addr_reg == 16'h0000 |-> rsp_error)
      else $error("address zero accepted");
   input_ro_a: assert property (rsp_valid && mb_reg && dig_reg == 4'h1 && op_reg != 8'h02
      |-> rsp_error) else $error("input bit area accepted other code");
   bad_op_a: assert property (rsp_valid && !mb_reg
      && !(op_reg inside {8'h20, 8'h00, 8'h04, 8'h1E, 8'h02, 8'h22}) |-> rsp_error)
      else $error("unknown native opcode accepted");
   coil_ok_a: assert property (rsp_valid && mb_reg && ok_addr && dig_reg == 4'h0
      && op_reg inside {8'h01, 8'h05, 8'h0F} |-> !rsp_error) else $error("coil code refused");
   hold_ok_a: assert property (rsp_valid && mb_reg && ok_addr && dig_reg == 4'h4
      && op_reg inside {8'h03, 8'h06, 8'h10} |-> !rsp_error) else $error("holding code refused");
endmodule : gateway_link_sva

// ==== gateway_message_router.sv ====
// Purpose: gateway end: local-route decision, opcode classing, local register space
// Assumes: one request in flight; originator keeps its own routing and class duties
// Notes:   scan grouping serialises entries sharing a target onto one slot
// Functional notes
// - same-target entries in span share one slot
// - four route cases act on local registers
// - reply route is exact reverse of peer route
// - leading digit picks area, one-based addresses
// - coils: read fc1, write fc5 or fc15
// - input bits read only, fc2
// - input registers read only, fc4
// - holding: read fc3, write fc6 or fc16
// - masked write fc22 is optional
// - random read fc100 only for meters
// - reads: 20 priority, 00, 04 random
// - writes: 1e priority/alarm, 02, 22 print
// - controllers originate priority messages only
// - non-priority write masks, priority overwrites
// - all native messages share one register space
`timescale 1ns/1ps
module gateway_message_router
   import gateway_router_pkg::*;
#(
   parameter int REG_DEPTH = 256,
   parameter int SLOTS     = 16
)(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   gateway_link_if.router  link,
   input  wire logic [7:0] port_drop,
   input  wire logic [7:0] owned_lo,
   input  wire logic [7:0] owned_hi,
   input  wire logic [7:0] scan_span,
   output logic            busy,
   output logic [7:0]      forward_drop
);
   // refuse sizes that the index and slot logic cannot hold
   if (REG_DEPTH < 2 || REG_DEPTH > 65536 || SLOTS < 1 || SLOTS > 256)
   begin : g_bad_params
      $error("gateway_message_router: unsupported parameters");
   end

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_RESP = 2'b10
   } state_e;

   localparam int AW = $clog2(REG_DEPTH);

   logic [15:0] regs [REG_DEPTH];
   state_e      state_reg, state_next;
   logic        local_reg, local_next;
   logic        err_reg, err_next;
   logic [15:0] data_reg, data_next;
   logic [7:0]  slot_reg, slot_next;
   logic [7:0]  fwd_reg, fwd_next;
   logic        wr_en;
   logic [15:0] wr_val;
   logic [AW-1:0] idx;
   logic [7:0]  tgt_tab [SLOTS];
   logic [7:0]  slot_cnt_reg;

   function automatic logic [7:0] drop_at(input logic [31:0] r, input logic [2:0] i);
      return r[8*i[1:0] +: 8];
   endfunction : drop_at

   // local-route decision
   logic       is_local;
   logic [7:0] last_drop;
   logic [7:0] prev_drop;
   logic       unowned;
   always_comb
   begin
      last_drop = 8'h00;
      prev_drop = 8'h00;
      unowned   = 1'b0;
      if (link.req_route_len != 3'h0)
         last_drop = drop_at(link.req_route, link.req_route_len - 3'h1);
      if (link.req_route_len > 3'h1)
         prev_drop = drop_at(link.req_route, link.req_route_len - 3'h2);
      // a drop outside the owned window ends routing here
      for (int i = 0; i < 4; i++)
         if (i < int'(link.req_route_len))
            if (drop_at(link.req_route, 3'(i)) < owned_lo
                || drop_at(link.req_route, 3'(i)) > owned_hi)
               unowned = 1'b1;
      is_local = (link.req_route_len == 3'h0)
                 || (last_drop == port_drop)
                 || (last_drop == `DROP_LOCAL_ALIAS && link.req_route_len > 3'h1
                     && prev_drop == port_drop)
                 || unowned;
   end

   // one-based addresses map onto zero-based storage
   assign idx = AW'(link.req_addr - 16'h0001);

   // request decode and response build
   always_comb
   begin
      state_next = state_reg;
      local_next = local_reg;
      err_next   = err_reg;
      data_next  = data_reg;
      slot_next  = slot_reg;
      fwd_next   = fwd_reg;
      wr_en      = 1'b0;
      wr_val     = regs[idx];
      case (state_reg)
         ST_IDLE:
         begin
            if (link.req_valid)
            begin
               local_next = is_local;
               err_next   = 1'b0;
               fwd_next   = (link.req_route_len != 3'h0) ? drop_at(link.req_route, 3'h0)
                                                         : `DROP_NONE;
               if (link.req_is_modbus)
                  err_next = !fc_legal(space_of(link.req_space_digit),
                                       link.req_opcode);
               else
                  err_next = (class_of(link.req_opcode) == CLS_BAD);
               if (link.req_addr == 16'h0000 || int'(link.req_addr) > REG_DEPTH)
                  err_next = 1'b1;
               state_next = ST_EXEC;
            end
         end
         ST_EXEC:
         begin
            data_next  = regs[idx];
            slot_next  = slot_cnt_reg;
            if (local_reg && !err_reg && !link.req_is_modbus)
            begin
               // one shared space for every native class
               case (class_of(link.req_opcode))
                  CLS_PRIO_WRITE:
                  begin
                     wr_en  = 1'b1;
                     wr_val = link.req_data;
                  end
                  CLS_NPRIO_WRT:
                  begin
                     wr_en  = 1'b1;
                     wr_val = (regs[idx] & ~link.req_mask)
                              | (link.req_data & link.req_mask);
                  end
                  default:
                     wr_en = 1'b0;
               endcase
            end
            state_next = ST_RESP;
         end
         ST_RESP:
            state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   // scan grouping: a target seen within the span reuses its slot
   logic [7:0] match_slot;
   logic       matched;
   always_comb
   begin
      matched    = 1'b0;
      match_slot = 8'h00;
      for (int i = 0; i < SLOTS; i++)
         if (i < int'(scan_span) && !matched && tgt_tab[i] == link.req_target)
         begin
            matched    = 1'b1;
            match_slot = 8'(i);
         end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_cnt_reg <= 8'h00;
         for (int i = 0; i < SLOTS; i++)
            tgt_tab[i] <= 8'h00;
      end
      else if (state_reg == ST_IDLE && link.req_valid)
      begin
         // requests are serviced one at a time, so a shared slot single-threads
         if (matched)
            slot_cnt_reg <= match_slot;
         else
         begin
            slot_cnt_reg <= (scan_span == 8'h00) ? 8'h00 :
                            8'((int'(slot_cnt_reg) + 1) % SLOTS);
            tgt_tab[(int'(slot_cnt_reg) + 1) % SLOTS] <= link.req_target;
         end
      end
   end

   // storage has no reset: it is a data array
   always_ff @(posedge clk_sys)
   begin
      if (wr_en)
         regs[idx] <= wr_val;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         local_reg <= 1'b0;
         err_reg   <= 1'b0;
         data_reg  <= `REG_RESET;
         slot_reg  <= 8'h00;
         fwd_reg   <= `DROP_NONE;
      end
      else
      begin
         state_reg <= state_next;
         local_reg <= local_next;
         err_reg   <= err_next;
         data_reg  <= data_next;
         slot_reg  <= slot_next;
         fwd_reg   <= fwd_next;
      end
   end

   // outputs registered from state_reg, req_valid and the next-state values
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.req_ready <= 1'b0;
         link.rsp_valid <= 1'b0;
         busy           <= 1'b0;
         forward_drop   <= `DROP_NONE;
      end
      else
      begin
         link.req_ready <= (state_reg == ST_IDLE) && link.req_valid;
         link.rsp_valid <= (state_next == ST_RESP);
         busy           <= (state_next != ST_IDLE);
         forward_drop   <= fwd_next;
      end
   end

   assign link.rsp_local = local_reg;
   assign link.rsp_error = err_reg;
   assign link.rsp_data  = data_reg;
   assign link.rsp_slot  = slot_reg;

endmodule : gateway_message_router

// ==== gateway_message_router_test.sv ====
// Purpose: drives originator user side against the router, both ends real
// Assumes: one request at a time, inputs changed on falling edge
// Notes:   expected values come from the table literals below
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module gateway_message_router_test;
   import gateway_router_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        start = 1'b0, is_controller = 1'b0, meter = 1'b1, has_mask = 1'b1;
   logic [7:0]  opcode = 8'h00, target = 8'h00, forward_drop;
   logic        is_modbus = 1'b0, busy, done, rejected, rej, loc, err;
   logic [3:0]  digit = 4'h0;
   logic [2:0]  route_len = 3'h0;
   logic [31:0] route = 32'h0, reply_route;
   logic [15:0] addr = 16'h0, data = 16'h0, mask = 16'h0, result;
   logic [7:0]  slot, s0, s1;
   logic [7:0]  port_drop = 8'h02, owned_lo = 8'h00, owned_hi = 8'hCF, span = 8'h08;
   int          bad_count = 0, n_tests = 0, cycles = 0;
   logic [31:0] rt_t [6] = '{32'h0, 32'h0210, 32'hCC02, 32'hE0, 32'h1005, 32'hCC05};
   logic [2:0]  ln_t [6] = '{3'h0, 3'h2, 3'h2, 3'h1, 3'h2, 3'h2};
   logic        lc_t [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
   logic [7:0]  op_t [7] = '{8'h20, 8'h00, 8'h04, 8'h1E, 8'h02, 8'h22, 8'h55};
   // digit, code, error expected
   logic [12:0] mb_t [12] = '{13'h0002, 13'h000A, 13'h001E, 13'h0204, 13'h0608, 13'h0806,
      13'h080C, 13'h0820, 13'h020B, 13'h060D, 13'h0007, 13'h0407};

   always #25 clk_sys = ~clk_sys;

   gateway_link_if u_link (.clk_sys(clk_sys));

   gateway_message_router #(.REG_DEPTH(256), .SLOTS(16)) u_gateway_message_router (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(u_link.router), .port_drop(port_drop),
      .owned_lo(owned_lo), .owned_hi(owned_hi), .scan_span(span), .busy(busy),
      .forward_drop(forward_drop));

   gateway_originator u_gateway_originator (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(u_link.originator), .start(start),
      .is_controller(is_controller), .target_is_meter(meter), .target_has_mask(has_mask),
      .opcode(opcode), .is_modbus(is_modbus), .space_digit(digit), .route_len(route_len),
      .route(route), .addr(addr), .data(data), .mask(mask), .target(target), .done(done),
      .rejected(rejected), .result(result), .reply_route(reply_route));

   gateway_link_sva #(.REG_DEPTH(256)) u_gateway_link_sva (
      .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(u_link.req_valid),
      .req_ready(u_link.req_ready), .req_opcode(u_link.req_opcode),
      .req_is_modbus(u_link.req_is_modbus), .req_space_digit(u_link.req_space_digit),
      .req_route_len(u_link.req_route_len), .req_addr(u_link.req_addr),
      .rsp_valid(u_link.rsp_valid), .rsp_local(u_link.rsp_local),
      .rsp_error(u_link.rsp_error), .rsp_data(u_link.rsp_data), .rsp_slot(u_link.rsp_slot));

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // one request; entered and left on a falling edge, fields held until done
   task automatic issue(input logic [7:0] op, input logic mb, input logic [3:0] dg,
      input logic [2:0] ln, input logic [31:0] rt, input logic [15:0] ad,
      input logic [15:0] dt, input logic [15:0] mk, input logic [7:0] tg);
      int n;
      opcode = op;
      is_modbus = mb;
      digit = dg;
      route_len = ln;
      route = rt;
      addr = ad;
      data = dt;
      mask = mk;
      target = tg;
      start = 1'b1;
      @(negedge clk_sys);
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && rejected !== 1'b1 && n < 40)
      begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("finish", 1'b1, done | rejected)
      rej = rejected;
      loc = u_link.rsp_local;
      err = u_link.rsp_error;
      slot = u_link.rsp_slot;
      @(negedge clk_sys);
   endtask : issue

   // hang guard, whole run needs well under a thousand cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         end_sim();
      end
   end

   initial
   begin
      repeat (20) @(negedge clk_sys);
      rst_n = 1'b1;
      `CHK("fwd reset", 8'hFF, forward_drop)
      `CHK("busy reset", 1'b0, busy)
      // local route decision, writes land only when local
      for (int i = 0; i < 6; i++)
      begin
         issue(8'h1E, 1'b0, 4'h0, ln_t[i], rt_t[i], 16'h0005, 16'h1234, 16'hFFFF, 8'h01);
         `CHK("local", lc_t[i], loc)
      end
      `CHK("fwd drop", 8'h05, forward_drop)
      // same route turns local once the port drop or owned window moves
      port_drop = 8'h10;
      issue(8'h20, 1'b0, 4'h0, 3'h2, 32'h1005, 16'h0005, 16'h0, 16'h0, 8'h01);
      `CHK("local port", 1'b1, loc)
      port_drop = 8'h02;
      owned_hi = 8'h04;
      issue(8'h20, 1'b0, 4'h0, 3'h2, 32'h1005, 16'h0005, 16'h0, 16'h0, 8'h01);
      `CHK("local unowned", 1'b1, loc)
      owned_hi = 8'hCF;
      issue(8'h20, 1'b0, 4'h0, 3'h0, 32'h0, 16'h0005, 16'h0000, 16'h0000, 8'h01);
      `CHK("prio read", 16'h1234, result)
      issue(8'h02, 1'b0, 4'h0, 3'h0, 32'h0, 16'h0005, 16'hABCD, 16'h00FF, 8'h01);
      issue(8'h00, 1'b0, 4'h0, 3'h0, 32'h0, 16'h0005, 16'h0000, 16'h0000, 8'h01);
      `CHK("masked write", 16'h12CD, result)
      issue(8'h1E, 1'b0, 4'h0, 3'h0, 32'h0, 16'h0005, 16'h5555, 16'h00FF, 8'h01);
      issue(8'h20, 1'b0, 4'h0, 3'h0, 32'h0, 16'h0005, 16'h0000, 16'h0000, 8'h01);
      `CHK("full write", 16'h5555, result)
      issue(8'h20, 1'b0, 4'h0, 3'h4, 32'h44332211, 16'h0001, 16'h0, 16'h0, 8'h01);
      `CHK("reply route", 32'h11223344, reply_route)
      // native opcode classes, last one unknown
      for (int i = 0; i < 7; i++)
      begin
         issue(op_t[i], 1'b0, 4'h0, 3'h0, 32'h0, 16'h0007, 16'h0001, 16'hFFFF, 8'h01);
         `CHK("op class", i == 6, err)
      end
      // controllers may only originate priority class
      is_controller = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         issue(op_t[i], 1'b0, 4'h0, 3'h0, 32'h0, 16'h0007, 16'h0001, 16'hFFFF, 8'h01);
         `CHK("ctrl class", i == 1 || i == 2 || i == 4, rej)
      end
      is_controller = 1'b0;
      // area by leading digit, every code except fc22 and fc100 on its area and a few misfits
      for (int i = 0; i < 12; i++)
      begin
         issue(mb_t[i][8:1], 1'b1, mb_t[i][12:9], 3'h0, 32'h0, 16'h0001, 16'h0, 16'h0, 8'h01);
         `CHK("area code", mb_t[i][0], err)
      end
      issue(8'h03, 1'b1, 4'h4, 3'h0, 32'h0, 16'h0000, 16'h0, 16'h0, 8'h01);
      `CHK("addr zero", 1'b1, err)
      // optional codes refused unless the target says it has them
      for (int k = 0; k < 2; k++)
      begin
         has_mask = k[0];
         meter = k[0];
         issue(8'h16, 1'b1, 4'h4, 3'h0, 32'h0, 16'h0001, 16'h0, 16'h00FF, 8'h01);
         `CHK("mask write", !k[0], rej)
         issue(8'h64, 1'b1, 4'h4, 3'h0, 32'h0, 16'h0001, 16'h0, 16'h0, 8'h01);
         `CHK("random read", !k[0], rej)
      end
      // same target within the span shares its slot
      issue(8'h03, 1'b1, 4'h4, 3'h0, 32'h0, 16'h0001, 16'h0, 16'h0, 8'hA1);
      s0 = slot;
      issue(8'h03, 1'b1, 4'h4, 3'h0, 32'h0, 16'h0001, 16'h0, 16'h0, 8'hB2);
      s1 = slot;
      issue(8'h03, 1'b1, 4'h4, 3'h0, 32'h0, 16'h0001, 16'h0, 16'h0, 8'hA1);
      `CHK("slot reuse", s0, slot)
      `CHK("slot apart", 1'b1, s1 !== s0)
      // a target outside the compared span gets a fresh slot
      span = 8'h02;
      issue(8'h03, 1'b1, 4'h4, 3'h0, 32'h0, 16'h0001, 16'h0, 16'h0, 8'hA1);
      `CHK("span limit", 1'b1, slot !== s0)
      end_sim();
   end
endmodule : gateway_message_router_test

// ==== gateway_originator.sv ====
// Purpose: peer end: issues a request, builds reply routes, keeps priority class
// Assumes: one outstanding request; user holds fields stable from start until done
// Notes:   replies reverse the stored route
`timescale 1ns/1ps
module gateway_originator
   import gateway_router_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   gateway_link_if.originator link,
   input  wire logic        start,
   input  wire logic        is_controller,
   input  wire logic        target_is_meter,
   input  wire logic        target_has_mask,
   input  wire logic [7:0]  opcode,
   input  wire logic        is_modbus,
   input  wire logic [3:0]  space_digit,
   input  wire logic [2:0]  route_len,
   input  wire logic [31:0] route,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] data,
   input  wire logic [15:0] mask,
   input  wire logic [7:0]  target,
   output logic             done,
   output logic             rejected,
   output logic [15:0]      result,
   output logic [31:0]      reply_route
);
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_REQ  = 2'b01,
      ST_WAIT = 2'b10
   } state_e;

   state_e state_reg, state_next;
   logic   allowed;

   function automatic logic [31:0] reverse_route(input logic [31:0] r, input logic [2:0] n);
      logic [31:0] o;
      o = 32'h0000_0000;
      for (int i = 0; i < 4; i++)
         if (i < int'(n))
            o[8*i +: 8] = r[8*(int'(n) - 1 - i) +: 8];
      return o;
   endfunction : reverse_route

   // own duties before issuing
   always_comb
   begin
      allowed = 1'b1;
      if (!is_modbus && is_controller
          && class_of(opcode) != CLS_PRIO_READ && class_of(opcode) != CLS_PRIO_WRITE
          && class_of(opcode) != CLS_PRINT)
         allowed = 1'b0;
      if (is_modbus && opcode == `FC_MASK_WRITE && !target_has_mask)
         allowed = 1'b0;
      if (is_modbus && opcode == `FC_RANDOM_READ && !target_is_meter)
         allowed = 1'b0;
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (start && allowed) state_next = ST_REQ;
         ST_REQ:  if (link.req_ready) state_next = ST_WAIT;
         ST_WAIT: if (link.rsp_valid) state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg   <= ST_IDLE;
         done        <= 1'b0;
         rejected    <= 1'b0;
         result      <= 16'h0000;
         reply_route <= 32'h0000_0000;
      end
      else
      begin
         state_reg <= state_next;
         done      <= (state_reg == ST_WAIT) && link.rsp_valid;
         rejected  <= (state_reg == ST_IDLE) && start && !allowed;
         if (state_reg == ST_WAIT && link.rsp_valid)
            result <= link.rsp_data;
         if (state_reg == ST_IDLE && start)
            reply_route <= reverse_route(route, route_len);
      end
   end

   assign link.req_valid       = (state_reg == ST_REQ);
   assign link.req_opcode      = opcode;
   assign link.req_is_modbus   = is_modbus;
   assign link.req_space_digit = space_digit;
   assign link.req_route_len   = route_len;
   assign link.req_route       = route;
   assign link.req_addr        = addr;
   assign link.req_data        = data;
   assign link.req_mask        = mask;
   assign link.req_target      = target;

endmodule : gateway_originator

// ==== gateway_router_map.svh ====
// Purpose: drop codes, function codes, opcodes, area digits and reset values for the message router
// Assumes: included by bare name from the package only
// Notes:   definitions only
`ifndef GATEWAY_ROUTER_MAP_SVH
`define GATEWAY_ROUTER_MAP_SVH

`define DROP_LOCAL_ALIAS   8'hCC
`define DROP_NONE          8'hFF
`define FC_READ_COILS      8'h01
`define FC_READ_INPUTS     8'h02
`define FC_READ_HOLDING    8'h03
`define FC_READ_INREGS     8'h04
`define FC_WRITE_COIL      8'h05
`define FC_WRITE_REG       8'h06
`define FC_WRITE_COILS     8'h0F
`define FC_WRITE_REGS      8'h10
`define FC_MASK_WRITE      8'h16
`define FC_RANDOM_READ     8'h64
`define OP_PRIO_READ       8'h20
`define OP_NPRIO_READ      8'h00
`define OP_NPRIO_RAND_READ 8'h04
`define OP_PRIO_WRITE      8'h1E
`define OP_NPRIO_WRITE     8'h02
`define OP_PRIO_PRINT      8'h22
`define SPACE_COIL         4'h0
`define SPACE_INPUT        4'h1
`define SPACE_INREG        4'h3
`define SPACE_HOLDING      4'h4
`define REG_RESET          16'h0000
`define SPAN_RESET         8'h08

`endif

// ==== gateway_router_pkg.sv ====
// Purpose: shared types and decode functions for the message router
// Assumes: map header supplies the numbers
// Notes:   class_of is used by both ends, space_of and fc_legal by the router only
`include "gateway_router_map.svh"
package gateway_router_pkg;

   typedef enum logic [2:0]
   {
      SPACE_COIL_E    = 3'b000,
      SPACE_INPUT_E   = 3'b001,
      SPACE_INREG_E   = 3'b010,
      SPACE_HOLDING_E = 3'b011,
      SPACE_BAD_E     = 3'b100
   } space_e;

   typedef enum logic [2:0]
   {
      CLS_PRIO_READ  = 3'b000,
      CLS_NPRIO_READ = 3'b001,
      CLS_RAND_READ  = 3'b010,
      CLS_PRIO_WRITE = 3'b011,
      CLS_NPRIO_WRT  = 3'b100,
      CLS_PRINT      = 3'b101,
      CLS_BAD        = 3'b110
   } op_class_e;

   // leading decimal digit of a modbus reference picks the area
   function automatic space_e space_of(input logic [3:0] digit);
      space_e s;
      s = SPACE_BAD_E;
      if (digit == `SPACE_COIL)
         s = SPACE_COIL_E;
      else if (digit == `SPACE_INPUT)
         s = SPACE_INPUT_E;
      else if (digit == `SPACE_INREG)
         s = SPACE_INREG_E;
      else if (digit == `SPACE_HOLDING)
         s = SPACE_HOLDING_E;
      return s;
   endfunction : space_of

   // is function code legal on that area
   function automatic logic fc_legal(input space_e sp, input logic [7:0] fc);
      logic ok;
      ok = 1'b0;
      case (sp)
         SPACE_COIL_E:    ok = (fc == `FC_READ_COILS) || (fc == `FC_WRITE_COIL)
                               || (fc == `FC_WRITE_COILS);
         SPACE_INPUT_E:   ok = (fc == `FC_READ_INPUTS);
         SPACE_INREG_E:   ok = (fc == `FC_READ_INREGS);
         SPACE_HOLDING_E: ok = (fc == `FC_READ_HOLDING) || (fc == `FC_WRITE_REG)
                               || (fc == `FC_WRITE_REGS) || (fc == `FC_MASK_WRITE)
                               || (fc == `FC_RANDOM_READ);
         default:         ok = 1'b0;
      endcase
      return ok;
   endfunction : fc_legal

   function automatic op_class_e class_of(input logic [7:0] op);
      op_class_e c;
      c = CLS_BAD;
      case (op)
         `OP_PRIO_READ:       c = CLS_PRIO_READ;
         `OP_NPRIO_READ:      c = CLS_NPRIO_READ;
         `OP_NPRIO_RAND_READ: c = CLS_RAND_READ;
         `OP_PRIO_WRITE:      c = CLS_PRIO_WRITE;
         `OP_NPRIO_WRITE:     c = CLS_NPRIO_WRT;
         `OP_PRIO_PRINT:      c = CLS_PRINT;
         default:             c = CLS_BAD;
      endcase
      return c;
   endfunction : class_of

endpackage : gateway_router_pkg
